/* File: hw/stps_clk_div.v */
// Divides the oscillator clock by 192 into a square wave.
// Assumes a single clock domain and synchronous active-high reset.
`include "stps_defines.vh"
`default_nettype none
module stps_clk_div (
  // Clock and reset.
  input wire clk_i,
  input wire sys_rst_i,
  // Divided clock level.
  output wire div_clk_o
);
  reg [7:0] cnt_q;
  reg lvl_q;
  ////////////////////////////////////////////////////////////////////////
  // The level toggles every half period, giving exactly 1/192 of clk.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end
    else if (cnt_q == `STPS_CLK_HALF - 8'h01)
    begin
      cnt_q <= 8'h00;
      lvl_q <= ~lvl_q;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign div_clk_o = lvl_q;
endmodule // stps_clk_div
`default_nettype wire

/* File: hw/stps_defines.vh */
// Constants for the status output pin select block: select codes,
// reset values and the clock divider count.
// Assumes the includer uses the macros as sized literals.
`ifndef STPS_DEFINES_VH
`define STPS_DEFINES_VH
`define STPS_SEL_W 6
`define STPS_SEL_RX_THR 6'h00
`define STPS_SEL_RX_THR_EOP 6'h01
`define STPS_SEL_TX_THR 6'h02
`define STPS_SEL_TX_FULL 6'h03
`define STPS_SEL_RX_OVF 6'h04
`define STPS_SEL_TX_UNF 6'h05
`define STPS_SEL_SYNC 6'h06
`define STPS_SEL_CRC_OK 6'h07
`define STPS_SEL_PQT 6'h08
`define STPS_SEL_CCA 6'h09
`define STPS_SEL_LOCK 6'h0A
`define STPS_SEL_CARRIER 6'h0E
`define STPS_SEL_HIZ 6'h2E
`define STPS_SEL_CLK_DIV 6'h3F
`define STPS_CFG_TEMP 8'h80
`define STPS_RST_CFG0 8'h3F
`define STPS_RST_CFG1 8'h2E
`define STPS_RST_CFG2 8'h29
`define STPS_CLK_DIV 8'hC0
`define STPS_CLK_HALF 8'h60
`endif

/* File: hw/stps_sync2.v */
// Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs are slow, independent status levels.
`default_nettype none
module stps_sync2 #(
  parameter W = 18
) (
  // Clock and reset.
  input wire clk_i,
  input wire sys_rst_i,
  // Raw and synchronised levels.
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  ////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second, to contain metastability.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // stps_sync2
`default_nettype wire

/* File: hw/stps_top.v */
// Status output pin select: routes internal radio status onto three pins.
// Assumes status inputs come from the radio core and may be asynchronous;
// chip select arrives from the pin and is synchronised here.
//
// Functional notes
// [RULE1] Three pins, each with 6-bit source select.
// [RULE2] Pin one valid only while chip select high.
// [RULE3] Pin one high-impedance after reset.
// [RULE4] Pin zero outputs oscillator/192 after reset.
// [RULE5] Host may rewrite pin zero select.
// [RULE6] Code 128 on pin zero: temperature sensor.
// [RULE7] 0x00: receive fill at or above threshold.
// [RULE8] 0x01: rx threshold or packet end, until empty.
// [RULE9] 0x02: transmit fill at or above threshold.
// [RULE10] 0x03: tx full, until below threshold.
// [RULE11] 0x04: rx overflow until flushed.
// [RULE12] 0x05: tx underflow until flushed.
// [RULE13] 0x06: sync seen until packet end.
// [RULE14] 0x06 rx: early drop on address/overflow.
// [RULE15] 0x07: crc ok until first read; code shows it only with legacy_compat_enable_i high, else drives low.
// [RULE16] 0x08: preamble quality above threshold.
// [RULE17] 0x09: clear channel per mode.
// [RULE18] 0x0A: synthesizer lock detector.
// [RULE19] 0x0E: carrier sense above threshold.
// [RULE20] Registered outputs; unassigned codes drive low.
`include "stps_defines.vh"
`default_nettype none
module stps_top (
  // Clock and reset.
  input wire clk_i,
  input wire sys_rst_i,
  // Configuration registers, written by the host side.
  input wire [7:0] pin_zero_config_reg_i,
  input wire [7:0] pin_one_config_reg_i,
  input wire [7:0] pin_two_config_reg_i,
  input wire cfg_wr_i,
  input wire legacy_compat_enable_i,
  // Chip select pin, active low.
  input wire chip_select_low_n_i,
  // Buffer status levels from the radio core.
  input wire rx_at_thr_i,
  input wire rx_empty_i,
  input wire rx_overflow_i,
  input wire rx_flush_i,
  input wire rx_first_read_i,
  input wire tx_at_thr_i,
  input wire tx_full_i,
  input wire tx_underflow_i,
  input wire tx_flush_i,
  // Packet and radio status levels.
  input wire tx_mode_i,
  input wire sync_seen_i,
  input wire packet_end_i,
  input wire addr_fail_i,
  input wire crc_ok_i,
  input wire pqi_above_i,
  input wire clear_channel_i,
  input wire pll_lock_i,
  input wire carrier_sense_i,
  // Pin drives.
  output reg status_pin_zero_o,
  output reg status_pin_zero_oe_o,
  output reg temp_sensor_en_o,
  output reg status_pin_one_o,
  output reg status_pin_one_oe_o,
  output reg status_pin_two_o,
  output reg status_pin_two_oe_o,
  // Current select fields, shown back for status.
  output reg [7:0] pin_zero_source_select_o,
  output reg [7:0] pin_one_source_select_o,
  output reg [7:0] pin_two_source_select_o
);
  ////////////////////////////////////////////////////////////////////////
  // Synchronisers on all signals from outside the clock domain.
  wire [17:0] raw_w;
  wire [17:0] syn_w;
  wire div_clk_w;
  wire cs_n_w;
  wire rx_thr_w;
  wire rx_empty_w;
  wire rx_ovf_w;
  wire rx_flush_w;
  wire rx_read_w;
  wire tx_thr_w;
  wire tx_full_w;
  wire tx_unf_w;
  wire tx_flush_w;
  wire tx_mode_w;
  wire sync_w;
  wire pkt_end_w;
  wire addr_fail_w;
  wire crc_w;
  wire pqi_w;
  wire cca_w;
  wire lock_w;
  wire cs_w;

  assign raw_w = {chip_select_low_n_i, rx_at_thr_i, rx_empty_i, rx_overflow_i, rx_flush_i,
                  rx_first_read_i, tx_at_thr_i, tx_full_i, tx_underflow_i, tx_flush_i,
                  tx_mode_i, sync_seen_i, packet_end_i, addr_fail_i, crc_ok_i,
                  pqi_above_i, clear_channel_i, pll_lock_i};
  assign {cs_n_w, rx_thr_w, rx_empty_w, rx_ovf_w, rx_flush_w, rx_read_w, tx_thr_w,
          tx_full_w, tx_unf_w, tx_flush_w, tx_mode_w, sync_w, pkt_end_w, addr_fail_w,
          crc_w, pqi_w, cca_w, lock_w} = syn_w;

  stps_sync2 #(
    .W(18)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(raw_w),
    .sync_o(syn_w)
  );

  // Carrier sense passes its own synchroniser to keep the vector tidy.
  reg cs_meta_q;
  reg cs_sync_q;
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_meta_q <= 1'b0;
      cs_sync_q <= 1'b0;
    end
    else
    begin
      cs_meta_q <= carrier_sense_i;
      cs_sync_q <= cs_meta_q;
    end
  end
  assign cs_w = cs_sync_q;

  // Oscillator divided by 192 for the default pin zero clock.
  stps_clk_div u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .div_clk_o(div_clk_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // Select field registers; the host may change them at any time.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_zero_source_select_o <= `STPS_RST_CFG0; // [RULE4]
      pin_one_source_select_o <= `STPS_RST_CFG1; // [RULE3]
      pin_two_source_select_o <= `STPS_RST_CFG2;
    end
    else if (cfg_wr_i)
    begin
      pin_zero_source_select_o <= pin_zero_config_reg_i; // [RULE5]
      pin_one_source_select_o <= pin_one_config_reg_i;
      pin_two_source_select_o <= pin_two_config_reg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status flags. A set arriving with its clear wins the cycle,
  // so no event is lost when both coincide.
  reg rx_eop_q;
  reg tx_full_q;
  reg rx_ovf_q;
  reg tx_unf_q;
  reg sync_q;
  reg crc_q;
  reg sync_prev_q;
  reg ovf_prev_q;
  reg unf_prev_q;
  wire sync_rise_w;
  wire sync_kill_w;

  assign sync_rise_w = sync_w & ~sync_prev_q;
  // Early end: underflow in transmit, address or overflow in receive.
  assign sync_kill_w = pkt_end_w | (tx_mode_w & tx_unf_w) |
                       (~tx_mode_w & (addr_fail_w | rx_ovf_w)); // [RULE13] [RULE14]

  // Previous levels for the edge detectors. They reset to the idle level
  // of their sources, so no false edge follows reset.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync_prev_q <= 1'b0;
      ovf_prev_q <= 1'b0;
      unf_prev_q <= 1'b0;
    end
    else
    begin
      sync_prev_q <= sync_w;
      ovf_prev_q <= rx_ovf_w;
      unf_prev_q <= tx_unf_w;
    end
  end

  // Code 0x01: threshold or packet end sets, an empty buffer clears.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      rx_eop_q <= 1'b0;
    else if (rx_thr_w | pkt_end_w)
      rx_eop_q <= 1'b1; // [RULE8]
    else if (rx_empty_w)
      rx_eop_q <= 1'b0; // [RULE8]
  end

  // Code 0x03: a full buffer sets, dropping below threshold clears.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      tx_full_q <= 1'b0;
    else if (tx_full_w)
      tx_full_q <= 1'b1; // [RULE10]
    else if (~tx_thr_w)
      tx_full_q <= 1'b0; // [RULE10]
  end

  // Code 0x04: the rising overflow sets, a flush clears.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      rx_ovf_q <= 1'b0;
    else if (rx_ovf_w & ~ovf_prev_q)
      rx_ovf_q <= 1'b1; // [RULE11]
    else if (rx_flush_w)
      rx_ovf_q <= 1'b0; // [RULE11]
  end

  // Code 0x05: the rising underflow sets, a flush clears.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      tx_unf_q <= 1'b0;
    else if (tx_unf_w & ~unf_prev_q)
      tx_unf_q <= 1'b1; // [RULE12]
    else if (tx_flush_w)
      tx_unf_q <= 1'b0; // [RULE12]
  end

  // Code 0x06: a sync rise sets; packet end or an early abort clears.
  // The set wins a tie so a new packet is never hidden by the last one.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      sync_q <= 1'b0;
    else if (sync_rise_w)
      sync_q <= 1'b1; // [RULE13]
    else if (sync_kill_w)
      sync_q <= 1'b0; // [RULE13] [RULE14]
  end

  // Code 0x07: a good packet end sets, the first buffer read clears.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      crc_q <= 1'b0;
    else if (crc_w & pkt_end_w)
      crc_q <= 1'b1; // [RULE15]
    else if (rx_read_w)
      crc_q <= 1'b0; // [RULE15]
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pin source mux; one function shared by all three pins.
  function src_sel;
    input [5:0] sel;
    begin
      case (sel)
        `STPS_SEL_RX_THR: src_sel = rx_thr_w; // [RULE7]
        `STPS_SEL_RX_THR_EOP: src_sel = rx_eop_q; // [RULE8]
        `STPS_SEL_TX_THR: src_sel = tx_thr_w; // [RULE9]
        `STPS_SEL_TX_FULL: src_sel = tx_full_q; // [RULE10]
        `STPS_SEL_RX_OVF: src_sel = rx_ovf_q; // [RULE11]
        `STPS_SEL_TX_UNF: src_sel = tx_unf_q; // [RULE12]
        `STPS_SEL_SYNC: src_sel = sync_q; // [RULE13]
        `STPS_SEL_CRC_OK: src_sel = crc_q & legacy_compat_enable_i; // [RULE15]
        `STPS_SEL_PQT: src_sel = pqi_w; // [RULE16]
        `STPS_SEL_CCA: src_sel = cca_w; // [RULE17]
        `STPS_SEL_LOCK: src_sel = lock_w; // [RULE18]
        `STPS_SEL_CARRIER: src_sel = cs_w; // [RULE19]
        `STPS_SEL_CLK_DIV: src_sel = div_clk_w; // [RULE4]
        default: src_sel = 1'b0; // [RULE20]
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registered pin drives. Pin one only drives while chip select is high,
  // because it doubles as the serial data-out line.
  // Pin zero stays driven through reset so a host clocked from it runs.
  // Temperature mode hands the pin to the analog sensor.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      status_pin_zero_o <= 1'b0;
      status_pin_zero_oe_o <= 1'b1; // [RULE4]
      temp_sensor_en_o <= 1'b0;
    end
    else
    begin
      temp_sensor_en_o <= (pin_zero_source_select_o == `STPS_CFG_TEMP); // [RULE6]
      status_pin_zero_oe_o <= (pin_zero_source_select_o != `STPS_CFG_TEMP); // [RULE6]
      status_pin_zero_o <= src_sel(pin_zero_source_select_o[5:0]); // [RULE1] [RULE20]
    end
  end

  // Pin one is released after reset, while selected, or in the release
  // code, so a shared serial bus is never fought over.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      status_pin_one_o <= 1'b0;
      status_pin_one_oe_o <= 1'b0; // [RULE3]
    end
    else
    begin
      status_pin_one_o <= src_sel(pin_one_source_select_o[5:0]); // [RULE1]
      status_pin_one_oe_o <= cs_n_w &
                             (pin_one_source_select_o[5:0] != `STPS_SEL_HIZ); // [RULE2] [RULE3]
    end
  end

  // Pin two is driven unless the release code is selected.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      status_pin_two_o <= 1'b0;
      status_pin_two_oe_o <= 1'b1;
    end
    else
    begin
      status_pin_two_o <= src_sel(pin_two_source_select_o[5:0]); // [RULE1]
      status_pin_two_oe_o <= (pin_two_source_select_o[5:0] != `STPS_SEL_HIZ);
    end
  end
endmodule // stps_top
`default_nettype wire

/* File: testbench/stps_host_model.sv */
// Host side: resolves the three pin lines and samples pin one.
// Assumes the host drives chip select itself.
`default_nettype none
module stps_host_model (
  // Clock and chip select.
  input wire logic clk_i,
  input wire logic chip_select_low_n_i,
  // Pin drives.
  input wire logic [2:0] pin_i,
  input wire logic [2:0] oe_i,
  // Line levels and the host's view of pin one.
  output var logic [2:0] line_o,
  output var logic pin_one_seen_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] last_q = 3'h0;
  // A released line has no pull, so it flips every cycle rather than hold.
  always_comb line_o = (pin_i & oe_i) | (~last_q & ~oe_i);
  always_ff @(posedge clk_i) last_q <= line_o;
  // The shared line is trusted only while deselected.
  always_ff @(posedge clk_i)
  begin
    if (chip_select_low_n_i) pin_one_seen_o <= line_o[1];
  end
endmodule // stps_host_model
`default_nettype wire

/* File: testbench/stps_top_properties.sv */
// Checker for the status pin select block, bound to its top.
// Assumes one clock domain and the top's own port names.
`default_nettype none
module stps_props (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Watched inputs.
  input wire logic cfg_wr_i,
  input wire logic [7:0] pin_zero_config_reg_i,
  input wire logic legacy_compat_enable_i,
  input wire logic chip_select_low_n_i,
  input wire logic rx_at_thr_i,
  input wire logic rx_flush_i,
  input wire logic pll_lock_i,
  // Watched outputs.
  input wire logic status_pin_zero_o,
  input wire logic status_pin_zero_oe_o,
  input wire logic temp_sensor_en_o,
  input wire logic status_pin_one_oe_o,
  input wire logic status_pin_two_o,
  input wire logic [7:0] pin_zero_source_select_o,
  input wire logic [7:0] pin_one_source_select_o,
  input wire logic [7:0] pin_two_source_select_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic last_q;
  logic armed_q;
  logic [7:0] run_q;
  wire logic sel_div = pin_zero_source_select_o == 8'h3F;
  wire logic flip = status_pin_zero_o != last_q;
  ////////////////////////////////////////////////////////////////////////////
  // Half-period counter; armed after one edge, since the first run is partial.
  always_ff @(posedge clk_i)
  begin
    last_q <= status_pin_zero_o;
    run_q <= flip ? 8'h01 : run_q + 8'h01;
    armed_q <= !sys_rst_i && sel_div && (armed_q || flip);
  end
  // Select held long enough for a status level to cross both stages.
  sequence s_rx_sel;
    (pin_zero_source_select_o == 8'h00) [*4];
  endsequence
  sequence s_lock_sel;
    (pin_two_source_select_o == 8'h0A) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_sel_load: assert property (
    cfg_wr_i |=> pin_zero_source_select_o == $past(pin_zero_config_reg_i))
    else $error("select field not loaded");
  chk_div_half: assert property (
    armed_q && sel_div && flip |-> run_q == 8'h60)
    else $error("divided clock half period wrong");
  chk_rx_level: assert property (
    s_rx_sel |-> status_pin_zero_o == $past(rx_at_thr_i, 3))
    else $error("pin zero does not follow receive level");
  chk_lock_out: assert property (
    s_lock_sel |-> status_pin_two_o == $past(pll_lock_i, 3))
    else $error("pin two does not follow lock");
  chk_flush_clear: assert property (
    (pin_zero_source_select_o == 8'h04) [*2] ##0 $fell(status_pin_zero_o)
      |-> $past(rx_flush_i, 4))
    else $error("overflow flag dropped without flush");
  chk_cs_release: assert property (
    (!chip_select_low_n_i) [*4] |-> !status_pin_one_oe_o)
    else $error("pin one driven while selected");
  chk_one_hiz: assert property (
    pin_one_source_select_o == 8'h2E |=> !status_pin_one_oe_o)
    else $error("pin one driven in high impedance code");
  chk_temp_mode: assert property (
    pin_zero_source_select_o == 8'h80 |=> temp_sensor_en_o && !status_pin_zero_oe_o)
    else $error("temperature mode not entered");
  chk_crc_mask: assert property (
    pin_two_source_select_o == 8'h07 && !legacy_compat_enable_i |=> !status_pin_two_o)
    else $error("crc flag shown without compat bit");
  chk_unused_low: assert property (
    pin_two_source_select_o == 8'h15 |=> !status_pin_two_o)
    else $error("unassigned code not low");
endmodule // stps_props
bind stps_top stps_props i_stps_props (.clk_i, .sys_rst_i, .cfg_wr_i,
  .pin_zero_config_reg_i, .legacy_compat_enable_i, .chip_select_low_n_i, .rx_at_thr_i,
  .rx_flush_i, .pll_lock_i, .status_pin_zero_o, .status_pin_zero_oe_o, .temp_sensor_en_o,
  .status_pin_one_oe_o, .status_pin_two_o, .pin_zero_source_select_o,
  .pin_one_source_select_o, .pin_two_source_select_o);
`default_nettype wire

/* File: testbench/test_stps_top.sv */
// Bench for the pin select block: reset state, divider and each code.
// Assumes the checker binds itself to the block.
`default_nettype none
module test_stps_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic cfg_wr = 1'h0;
  logic cs_n = 1'h1;
  logic b;
  logic [7:0] c0 = 8'h00;
  logic [7:0] c1 = 8'h00;
  logic [7:0] c2 = 8'h00;
  logic [18:0] st = 19'h00000;
  logic [2:0] pin, oe, line;
  logic temp_en, seen1;
  logic [7:0] s0, s1, s2;
  int failures = 0;
  int n_tests = 0;
  int k;
  always #5 clk_i = ~clk_i;
  stps_top i_stps_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr),
    .pin_zero_config_reg_i(c0), .pin_one_config_reg_i(c1), .pin_two_config_reg_i(c2),
    .legacy_compat_enable_i(st[18]), .chip_select_low_n_i(cs_n), .rx_at_thr_i(st[0]),
    .rx_empty_i(st[1]), .rx_overflow_i(st[2]), .rx_flush_i(st[3]), .rx_first_read_i(st[4]),
    .tx_at_thr_i(st[5]), .tx_full_i(st[6]), .tx_underflow_i(st[7]), .tx_flush_i(st[8]),
    .tx_mode_i(st[9]), .sync_seen_i(st[10]), .packet_end_i(st[11]), .addr_fail_i(st[12]),
    .crc_ok_i(st[13]), .pqi_above_i(st[14]), .clear_channel_i(st[15]), .pll_lock_i(st[16]),
    .carrier_sense_i(st[17]), .status_pin_zero_o(pin[0]), .status_pin_zero_oe_o(oe[0]),
    .temp_sensor_en_o(temp_en), .status_pin_one_o(pin[1]), .status_pin_one_oe_o(oe[1]),
    .status_pin_two_o(pin[2]), .status_pin_two_oe_o(oe[2]), .pin_zero_source_select_o(s0),
    .pin_one_source_select_o(s1), .pin_two_source_select_o(s2));
  stps_host_model i_stps_host_model (.clk_i(clk_i), .chip_select_low_n_i(cs_n),
    .pin_i(pin), .oe_i(oe), .line_o(line), .pin_one_seen_o(seen1));
  ////////////////////////////////////////////////////////////////////////////
  // Checks sit 1 ns past the edge so the outputs have settled.
  task cy(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task put(input logic [18:0] v);
    @(posedge clk_i);
    st <= v;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] m, input logic [7:0] c);
    @(posedge clk_i);
    c0 <= a;
    c1 <= m;
    c2 <= c;
    cfg_wr <= 1'h1;
    @(posedge clk_i);
    cfg_wr <= 1'h0;
    cy(3);
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A plain level source must follow both ways on pins zero and two.
  task lvl(input logic [7:0] c, input logic [18:0] v);
    wr(c, 8'h2E, c);
    put(v);
    cy(6);
    chk_bit("level high", 1'h1, pin[2]);
    chk_bit("level high zero", 1'h1, pin[0]);
    put(19'h00000);
    cy(6);
    chk_bit("level low", 1'h0, pin[2]);
    chk_bit("level low zero", 1'h0, pin[0]);
  endtask
  // A sticky source: one set pulse, then the clearing event.
  task stk(input logic [7:0] c, input logic [18:0] h, input logic [18:0] s,
           input logic [18:0] r, input logic e);
    wr(c, 8'h2E, c);
    put(h | s);
    put(h);
    cy(6);
    chk_bit("sticky set", e, pin[2]);
    put(h ^ r);
    cy(6);
    chk_bit("sticky clear", 1'h0, pin[2]);
    put(19'h00000);
    cy(2);
  endtask
  task summarize;
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    cy(1);
    chk_byte("select one", 8'h2E, s1);
    chk_bit("pin one enable", 1'h0, oe[1]);
    chk_byte("select zero", 8'h3F, s0);
    chk_bit("pin zero enable", 1'h1, oe[0]);
    chk_byte("select two", 8'h29, s2);
    chk_bit("pin two enable", 1'h1, oe[2]);
    for (int i = 0; i < 2; i++)
    begin
      b = pin[0];
      k = 0;
      while (pin[0] === b && k < 300)
      begin
        cy(1);
        k++;
      end
    end
    chk_byte("half period", 8'h60, k[7:0]);
    wr(8'h3F, 8'h00, 8'h29);
    put(19'h00001);
    cy(6);
    chk_bit("pin one enable", 1'h1, oe[1]);
    chk_bit("pin one seen", 1'h1, seen1);
    @(posedge clk_i);
    cs_n <= 1'h0;
    cy(5);
    chk_bit("pin one released", 1'h0, oe[1]);
    @(posedge clk_i);
    cs_n <= 1'h1;
    wr(8'h80, 8'h2E, 8'h15);
    put(19'h7FFFF);
    cy(6);
    chk_bit("temp enable", 1'h1, temp_en);
    chk_bit("pin zero released", 1'h0, oe[0]);
    chk_bit("unassigned code", 1'h0, pin[2]);
    put(19'h00000);
    lvl(8'h00, 19'h00001);
    lvl(8'h02, 19'h00020);
    lvl(8'h08, 19'h04000);
    lvl(8'h09, 19'h08000);
    lvl(8'h0A, 19'h10000);
    lvl(8'h0E, 19'h20000);
    stk(8'h01, 19'h00000, 19'h00001, 19'h00002, 1'h1);
    stk(8'h03, 19'h00020, 19'h00040, 19'h00020, 1'h1);
    stk(8'h04, 19'h00000, 19'h00004, 19'h00008, 1'h1);
    stk(8'h05, 19'h00000, 19'h00080, 19'h00100, 1'h1);
    stk(8'h06, 19'h00000, 19'h00400, 19'h00800, 1'h1);
    stk(8'h06, 19'h00200, 19'h00400, 19'h00080, 1'h1);
    stk(8'h06, 19'h00000, 19'h00400, 19'h01000, 1'h1);
    stk(8'h06, 19'h00000, 19'h00400, 19'h00004, 1'h1);
    stk(8'h07, 19'h40000, 19'h02800, 19'h00010, 1'h1);
    stk(8'h07, 19'h00000, 19'h02800, 19'h00010, 1'h0);
    summarize();
  end
  // Watchdog: about seventeen times the expected run.
  initial
  begin
    #100000;
    failures++;
    summarize();
  end
endmodule // test_stps_top
`default_nettype wire
